// ==== hdl/alm_cfg.svh ====
`ifndef ALM_CFG_SVH
`define ALM_CFG_SVH
// register pointer codes on the byte-wide register port
`define ALM_PTR_RESULT 4'h0
`define ALM_PTR_STATUS 4'h1
`define ALM_PTR_CONFIG 4'h2
`define ALM_PTR_LIMIT_BASE 4'h4
`define ALM_PTR_LIMIT_LAST 4'hf
// result word field positions
`define ALM_FLAG_BIT 15
`define ALM_TAG_HI 14
`define ALM_TAG_LO 12
// config field positions
`define ALM_CFG_POL 0
`define ALM_CFG_FUNC 1
`define ALM_CFG_EN 2
`define ALM_CFG_RESET 16'h0008
// scale values
`define ALM_FULL_SCALE 12'hfff
`define ALM_ZERO_SCALE 12'h000
`define ALM_HYST_10BIT 12'h002
`define ALM_HYST_12BIT 12'h008
`define ALM_LSB_MASK_10BIT 12'hffc
`define ALM_CLEAR_ALL 8'hff
`define ALM_MON_CHANNELS 4
`endif

// ==== hdl/alm_pkg.sv ====
package alm_pkg;
    // one finished conversion as handed in by the converter core
    typedef struct packed {
        logic [2:0] tag;
        logic [11:0] value;
    } alm_sample_type;
    // one register port access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [3:0] ptr;
        logic [15:0] wdata;
    } alm_access_type;
    typedef enum logic [1:0] {ALM_PIN_OFF, ALM_PIN_BUSY, ALM_PIN_ALERT} alm_pin_type;
endpackage

// ==== hdl/alm_limit_mem.sv ====
`timescale 1ns/1ps
`include "alm_cfg.svh"
// twelve limit words: index = channel*3 + {0 upper, 1 lower, 2 hysteresis}
module alm_limit_mem
    import alm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_variant_10bit,
    input wire logic i_we,
    input wire logic [3:0] i_waddr,
    input wire logic [11:0] i_wdata,
    input wire logic i_mm_we,
    input wire logic [1:0] i_mm_ch,
    input wire logic [11:0] i_mm_value,
    input wire logic [3:0] i_raddr,
    output logic [11:0] o_rdata,
    output logic [143:0] o_all
);
    logic [11:0] mem_reg [0:11];
    genvar gi;
    // power-up defaults per word kind; hysteresis default follows the variant
    generate
        for (gi = 0; gi < 12; gi++)
        begin : g_word
            always_ff @(posedge i_clk_sys)
            begin
                if (!i_reset_n)
                begin
                    if (gi % 3 == 0)
                        mem_reg[gi] <= `ALM_FULL_SCALE;
                    else if (gi % 3 == 1)
                        mem_reg[gi] <= `ALM_ZERO_SCALE;
                    else
                        mem_reg[gi] <= i_variant_10bit ? `ALM_HYST_10BIT : `ALM_HYST_12BIT;
                end
                // upper and lower words both track in one sample; a host write there is lost
                else if (i_ce && i_mm_we && i_mm_ch == 2'(gi / 3) && gi % 3 == 0
                         && i_mm_value > mem_reg[gi])
                    mem_reg[gi] <= i_mm_value;
                else if (i_ce && i_mm_we && i_mm_ch == 2'(gi / 3) && gi % 3 == 1
                         && i_mm_value < mem_reg[gi])
                    mem_reg[gi] <= i_mm_value;
                else if (i_ce && i_we && i_waddr == 4'(gi))
                    mem_reg[gi] <= i_wdata;
            end
            assign o_all[gi*12 +: 12] = mem_reg[gi];
        end
    endgenerate
    // registered read port
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            o_rdata <= `ALM_ZERO_SCALE;
        else if (i_ce)
            o_rdata <= (i_raddr < 4'd12) ? o_all[i_raddr*12 +: 12] : `ALM_ZERO_SCALE;
    end
endmodule

// ==== hdl/alm_byte_pair.sv ====
`timescale 1ns/1ps
`include "alm_cfg.svh"
// serialises a 16-bit word into two bytes, high byte first
module alm_byte_pair
    import alm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_load,
    input wire logic [15:0] i_word,
    input wire logic i_next,
    output logic [7:0] o_byte,
    output logic o_second
);
    logic [7:0] low_reg;
    // latch low half so it matches the high half taken together
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            o_byte <= 8'h00;
            low_reg <= 8'h00;
            o_second <= 1'b0;
        end
        else if (i_ce)
        begin
            if (i_load)
            begin
                o_byte <= i_word[15:8];
                low_reg <= i_word[7:0];
                o_second <= 1'b0;
            end
            else if (i_next && !o_second)
            begin
                o_byte <= low_reg;
                o_second <= 1'b1;
            end
        end
    end
endmodule

// ==== hdl/alm_monitor.sv ====
`timescale 1ns/1ps
`include "alm_cfg.svh"
module alm_monitor
    import alm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_ce,
    input wire logic i_variant_10bit,
    input wire logic i_sample_valid,
    input wire alm_sample_type i_sample,
    input wire logic i_busy,
    input wire alm_access_type i_access,
    input wire logic i_rd_next,
    output logic [15:0] o_rdata,
    output logic [7:0] o_result_byte,
    output logic o_result_second,
    output logic [7:0] o_status,
    output logic o_alert_pin
);
    logic [15:0] config_reg;
    logic [7:0] status_reg;
    logic [7:0] active_reg;
    logic [7:0] status_next;
    logic [7:0] active_next;
    logic [15:0] result_reg;
    logic [143:0] lim_all;
    logic [11:0] mem_rdata;
    logic mem_we;
    logic [3:0] mem_waddr;
    logic [11:0] mem_wdata;
    logic [11:0] value_masked;
    logic mon_ch;
    logic [1:0] ch;
    logic [11:0] up_lim;
    logic [11:0] lo_lim;
    logic [11:0] hyst;
    logic minmax;
    logic clear_req;
    logic rd_ptr_limit_reg;
    logic mm_we;
    alm_pin_type pin_mode;

    // 10-bit variant keeps the value left aligned with low bits zero
    assign value_masked = i_variant_10bit ? (i_sample.value & `ALM_LSB_MASK_10BIT)
                                          : i_sample.value;
    // only inputs 1..4 (tags 0..3) carry limits
    assign mon_ch = (i_sample.tag[2] == 1'b0);
    assign ch = i_sample.tag[1:0];
    assign up_lim = lim_all[(ch*3)*12 +: 12];
    assign lo_lim = lim_all[(ch*3+1)*12 +: 12];
    assign hyst = lim_all[(ch*3+2)*12 +: 12];
    assign minmax = (hyst == `ALM_FULL_SCALE);
    assign clear_req = i_access.wr && i_access.ptr == `ALM_PTR_CONFIG
                       && i_access.wdata[`ALM_CFG_EN] && i_access.wdata[`ALM_CFG_FUNC];
    // min/max channels move their upper and lower words inside the memory
    assign mm_we = i_sample_valid && mon_ch && minmax;

    // violation tracking with hysteresis, new events win over clears
    always_comb
    begin
        active_next = active_reg;
        status_next = status_reg;
        if (clear_req)
        begin
            active_next = 8'h00;
            status_next = 8'h00;
        end
        else if (i_access.wr && i_access.ptr == `ALM_PTR_STATUS
                 && i_access.wdata[7:0] == `ALM_CLEAR_ALL)
            status_next = 8'h00;
        if (i_sample_valid && mon_ch && !minmax)
        begin
            if (value_masked > up_lim)
            begin
                active_next[ch*2+1] = 1'b1;
                status_next[ch*2+1] = 1'b1;
            end
            else if ({1'b0, value_masked} + {1'b0, hyst} <= {1'b0, up_lim})
                active_next[ch*2+1] = 1'b0;
            if (value_masked < lo_lim)
            begin
                active_next[ch*2] = 1'b1;
                status_next[ch*2] = 1'b1;
            end
            else if ({1'b0, value_masked} >= {1'b0, lo_lim} + {1'b0, hyst})
                active_next[ch*2] = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            active_reg <= 8'h00;
            status_reg <= 8'h00;
        end
        else if (i_ce)
        begin
            active_reg <= active_next;
            status_reg <= status_next;
        end
    end

    // host port into the limit words; tracking updates take priority inside the memory
    always_comb
    begin
        mem_we = 1'b0;
        mem_waddr = 4'h0;
        mem_wdata = `ALM_ZERO_SCALE;
        if (i_access.wr && i_access.ptr >= `ALM_PTR_LIMIT_BASE)
        begin
            mem_we = 1'b1;
            mem_waddr = i_access.ptr - `ALM_PTR_LIMIT_BASE;
            mem_wdata = i_access.wdata[11:0];
        end
    end

    alm_limit_mem u_mem (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_variant_10bit(i_variant_10bit),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_mm_we(mm_we),
        .i_mm_ch(ch),
        .i_mm_value(value_masked),
        .i_raddr(i_access.ptr - `ALM_PTR_LIMIT_BASE),
        .o_rdata(mem_rdata),
        .o_all(lim_all)
    );

    // config: a clear request stores enable one, function zero
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            config_reg <= `ALM_CFG_RESET;
        else if (i_ce && i_access.wr && i_access.ptr == `ALM_PTR_CONFIG)
        begin
            config_reg <= i_access.wdata;
            if (clear_req)
                config_reg[`ALM_CFG_FUNC] <= 1'b0;
        end
    end

    // result word built when a sample lands
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            result_reg <= 16'h0000;
        else if (i_ce && i_sample_valid)
            result_reg <= {1'b0, i_sample.tag, value_masked};
    end

    alm_byte_pair u_pair (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_ce(i_ce),
        .i_load(i_access.rd && i_access.ptr == `ALM_PTR_RESULT),
        .i_word({(|active_reg), result_reg[14:0]}),
        .i_next(i_rd_next),
        .o_byte(o_result_byte),
        .o_second(o_result_second)
    );

    // word-wide register read, one cycle after the request, limit words one cycle later
    // one-cycle pulse, so the limit answer then stands until the next read
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            rd_ptr_limit_reg <= 1'b0;
        else if (i_ce)
            rd_ptr_limit_reg <= i_access.rd && (i_access.ptr >= `ALM_PTR_LIMIT_BASE);
    end
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
            o_rdata <= 16'h0000;
        else if (i_ce && i_access.rd)
        begin
            case (i_access.ptr)
                `ALM_PTR_RESULT: o_rdata <= {(|active_reg), result_reg[14:0]};
                `ALM_PTR_STATUS: o_rdata <= {8'h00, status_reg};
                `ALM_PTR_CONFIG: o_rdata <= config_reg;
                default: o_rdata <= 16'h0000; // limit words follow from the memory
            endcase
        end
        else if (i_ce && rd_ptr_limit_reg)
            o_rdata <= {4'h0, mem_rdata};
    end

    // pin function decode
    always_comb
    begin
        case ({config_reg[`ALM_CFG_EN], config_reg[`ALM_CFG_FUNC]})
            2'b10: pin_mode = ALM_PIN_ALERT;
            2'b01: pin_mode = ALM_PIN_BUSY;
            default: pin_mode = ALM_PIN_OFF;
        endcase
    end

    // pin level registered; inactive level follows polarity too
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_reset_n)
        begin
            o_alert_pin <= 1'b1;
            o_status <= 8'h00;
        end
        else if (i_ce)
        begin
            o_status <= status_next;
            case (pin_mode)
                ALM_PIN_ALERT: o_alert_pin <= (|active_next) ~^ config_reg[`ALM_CFG_POL];
                ALM_PIN_BUSY: o_alert_pin <= i_busy ~^ config_reg[`ALM_CFG_POL];
                default: o_alert_pin <= ~config_reg[`ALM_CFG_POL];
            endcase
        end
    end

    // checks
    upper_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && i_sample_valid && mon_ch && !minmax && value_masked > up_lim && !clear_req
        |=> status_reg[$past(ch)*2+1] && active_reg[$past(ch)*2+1])
        else $error("upper violation not recorded");
    lower_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && i_sample_valid && mon_ch && !minmax && value_masked < lo_lim
        |=> active_reg[$past(ch)*2])
        else $error("lower violation not recorded");
    clear_all_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && clear_req && !i_sample_valid |=> status_reg == 8'h00 && active_reg == 8'h00)
        else $error("clear request left violations");
    status_clr_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && i_access.wr && i_access.ptr == `ALM_PTR_STATUS
        && i_access.wdata[7:0] == `ALM_CLEAR_ALL && !i_sample_valid |=> status_reg == 8'h00)
        else $error("status not cleared");
    sticky_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && !i_access.wr |=> (status_reg & $past(status_reg)) == $past(status_reg))
        else $error("status bit lost");
    cfg_back_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && clear_req |=> config_reg[`ALM_CFG_EN] && !config_reg[`ALM_CFG_FUNC])
        else $error("config readback wrong");
    pin_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && pin_mode == ALM_PIN_OFF |=> o_alert_pin == !$past(config_reg[`ALM_CFG_POL]))
        else $error("idle pin active");
    minmax_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && i_sample_valid && mon_ch && minmax && !clear_req
        |=> active_reg == $past(active_reg))
        else $error("min/max channel raised violation");
    result_word_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && i_sample_valid
        |=> result_reg[14:0] == {$past(i_sample.tag), $past(value_masked)})
        else $error("result word fields wrong");
    flag_live_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && i_access.rd && i_access.ptr == `ALM_PTR_RESULT
        |=> o_rdata[`ALM_FLAG_BIT] == $past(|active_reg))
        else $error("result flag not live");
    byte_load_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && i_access.rd && i_access.ptr == `ALM_PTR_RESULT
        |=> o_result_byte == o_rdata[15:8] && !o_result_second)
        else $error("first result byte wrong");
    lim_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && rd_ptr_limit_reg && !i_access.rd |=> o_rdata == {4'h0, $past(mem_rdata)})
        else $error("limit word read wrong");
    mon_only_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && i_sample_valid && !mon_ch && !i_access.wr
        |=> active_reg == $past(active_reg) && status_reg == $past(status_reg))
        else $error("unmonitored channel changed violations");
    max_track_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && mm_we && value_masked > up_lim
        |=> lim_all[($past(ch)*3)*12 +: 12] == $past(value_masked))
        else $error("maximum not stored");
    min_track_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && mm_we && value_masked < lo_lim
        |=> lim_all[($past(ch)*3+1)*12 +: 12] == $past(value_masked))
        else $error("minimum not stored");
    // pin level per mode, polarity applied in both functions
    busy_pin_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && pin_mode == ALM_PIN_BUSY
        |=> o_alert_pin == ($past(i_busy) ~^ $past(config_reg[`ALM_CFG_POL])))
        else $error("busy pin level wrong");
    alert_pin_a: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_ce && pin_mode == ALM_PIN_ALERT
        |=> o_alert_pin == ((|active_reg) ~^ $past(config_reg[`ALM_CFG_POL])))
        else $error("alert pin level wrong");

    // main scenarios reached
    cov_up_c: cover property (@(posedge i_clk_sys) i_sample_valid && mon_ch && value_masked > up_lim);
    cov_clr_c: cover property (@(posedge i_clk_sys) clear_req);
    cov_mm_c: cover property (@(posedge i_clk_sys) i_sample_valid && mon_ch && minmax);
    cov_lo_c: cover property (@(posedge i_clk_sys)
        i_sample_valid && mon_ch && value_masked < lo_lim);
    cov_busy_c: cover property (@(posedge i_clk_sys) pin_mode == ALM_PIN_BUSY && i_busy);
endmodule

// ==== dv/alm_host_model.sv ====
`timescale 1ns/1ps
// serial host stand-in: one register access at a time on the byte port
module alm_host_model
    import alm_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_variant_10bit,
    output alm_access_type o_access,
    output logic o_rd_next
);
    initial
    begin
        o_access = '0;
        o_rd_next = 1'b0;
    end
    // raised on a falling edge, taken at the rising one, idle gap after
    task automatic acc(input logic w, input logic [3:0] p, input logic [15:0] d);
        @(negedge i_clk_sys);
        o_access = '{w, !w, p, d};
        @(negedge i_clk_sys);
        o_access = '0;
        repeat (2) @(negedge i_clk_sys);
    endtask
    // limit words: unused high bits and 10-bit low bits sent as zero
    task automatic wr(input logic [3:0] p, input logic [15:0] d);
        logic [15:0] m;
        m = d;
        if (p >= 4'h4)
            m = {4'h0, d[11:0] & (i_variant_10bit ? 12'hffc : 12'hfff)};
        acc(1'b1, p, m);
    endtask
    task automatic rd(input logic [3:0] p);
        acc(1'b0, p, 16'h0000);
    endtask
    // second byte of a result word
    task automatic next_byte();
        @(negedge i_clk_sys);
        o_rd_next = 1'b1;
        @(negedge i_clk_sys);
        o_rd_next = 1'b0;
    endtask
endmodule

// ==== dv/alm_monitor_bench.sv ====
`timescale 1ns/1ps
module alm_monitor_bench;
    import alm_pkg::*;
    logic i_clk_sys, i_reset_n, i_variant_10bit, i_sample_valid, i_busy, i_ce;
    logic o_result_second, o_alert_pin, rd_next;
    alm_sample_type i_sample;
    alm_access_type acc;
    logic [15:0] o_rdata, last, lastw;
    logic [7:0] o_result_byte, o_status, stat;
    logic [15:0] exp_q[$];
    logic [11:0] up[4], lo[4], hy[4];
    logic [3:0] vh, vl;
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 30;

    alm_monitor DUT (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_ce(i_ce),
        .i_variant_10bit(i_variant_10bit), .i_sample_valid(i_sample_valid),
        .i_sample(i_sample), .i_busy(i_busy), .i_access(acc), .i_rd_next(rd_next),
        .o_rdata(o_rdata), .o_result_byte(o_result_byte),
        .o_result_second(o_result_second), .o_status(o_status),
        .o_alert_pin(o_alert_pin));
    alm_host_model HOST (.i_clk_sys(i_clk_sys), .i_variant_10bit(i_variant_10bit),
        .o_access(acc), .o_rd_next(rd_next));

    initial
    begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // answers land just after the taking edge, limit words one edge later
    always @(posedge i_clk_sys)
    begin
        if (acc.rd)
            fork
                automatic logic [3:0] p = acc.ptr;
                automatic logic [15:0] e = exp_q.pop_front();
                begin
                    if (p >= 4'h4)
                        @(posedge i_clk_sys);
                    #1;
                    check(o_rdata, e);
                    if (p == 4'h0)
                        lastw = e;
                    if (p == 4'h0)
                        check({8'h00, o_result_byte}, {8'h00, e[15:8]});
                    if (p == 4'h1)
                        check({8'h00, o_status}, e);
                end
            join_none
        if (rd_next)
            fork
                begin
                    #1;
                    check({o_result_second, 7'h00, o_result_byte}, {8'h80, lastw[7:0]});
                end
            join_none
    end

    task automatic rd(input logic [3:0] p, input logic [15:0] e);
        exp_q.push_back(e);
        HOST.rd(p);
    endtask

    // sample into the block and into the reference limit model
    task automatic smp(input logic [2:0] t, input logic [11:0] v);
        int c;
        c = t;
        @(negedge i_clk_sys);
        i_sample_valid = 1'b1;
        i_sample = '{t, v};
        @(negedge i_clk_sys);
        i_sample_valid = 1'b0;
        if (i_variant_10bit)
            v = v & 12'hffc;
        if (c < 4 && hy[c] == 12'hfff)
        begin
            up[c] = (v > up[c]) ? v : up[c];
            lo[c] = (v < lo[c]) ? v : lo[c];
        end
        else if (c < 4)
        begin
            vh[c] = (v > up[c]) | (vh[c] & (int'(v) > int'(up[c]) - int'(hy[c])));
            vl[c] = (v < lo[c]) | (vl[c] & (int'(v) < int'(lo[c]) + int'(hy[c])));
            stat[2 * c + 1] = stat[2 * c + 1] | (v > up[c]);
            stat[2 * c] = stat[2 * c] | (v < lo[c]);
        end
        last = {|{vh, vl}, t, v};
    endtask

    task automatic lim(input int c, input int k, input logic [11:0] v);
        HOST.wr(4'(4 + c * 3 + k), {4'h0, v});
        case (k)
            0: up[c] = v;
            1: lo[c] = v;
            default: hy[c] = v;
        endcase
    endtask

    task automatic do_reset(input logic v10);
        @(negedge i_clk_sys);
        i_reset_n = 1'b0;
        i_variant_10bit = v10;
        repeat (8) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            up[c] = 12'hfff;
            lo[c] = 12'h000;
            hy[c] = v10 ? 12'h002 : 12'h008;
        end
        vh = 4'h0;
        vl = 4'h0;
        stat = 8'h00;
    endtask

    // watchdog: the whole sequence needs well under 10 us
    initial
    begin
        #100us;
        n_mismatch++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        i_reset_n = 1'b0;
        i_variant_10bit = 1'b0;
        i_sample_valid = 1'b0;
        i_sample = '0;
        i_busy = 1'b0;
        i_ce = 1'b1;
        do_reset(1'b0);
        rd(4'h1, 16'h0000);
        rd(4'h2, 16'h0008);
        for (int c = 0; c < 4; c++)
        begin
            rd(4'(4 + c * 3), 16'h0fff);
            rd(4'(5 + c * 3), 16'h0000);
            rd(4'(6 + c * 3), 16'h0008);
        end
        $display("reset values done");
        for (int t = 0; t < 8; t++)
        begin
            smp(3'(t), 12'($random(seed)));
            rd(4'h0, last);
            HOST.next_byte();
        end
        $display("result format done");
        lim(0, 0, 12'h800);
        lim(0, 1, 12'h100);
        lim(0, 2, 12'h010);
        smp(3'd0, 12'h800);
        rd(4'h0, last);
        smp(3'd0, 12'h801);
        rd(4'h0, last);
        smp(3'd0, 12'h7f1);
        rd(4'h0, last);
        smp(3'd0, 12'h7f0);
        rd(4'h0, last);
        lim(1, 1, 12'h100);
        smp(3'd1, 12'h0ff);
        smp(3'd6, 12'h123);
        rd(4'h0, last);
        smp(3'd1, 12'h107);
        rd(4'h0, last);
        smp(3'd1, 12'h108);
        rd(4'h0, last);
        lim(3, 0, 12'h010);
        smp(3'd3, 12'h011);
        rd(4'h1, {8'h00, stat});
        $display("limits done");
        // pin in every mode while a violation is held
        for (int k = 0; k < 6; k++)
        begin
            i_busy = 1'($random(seed));
            HOST.wr(4'h2, 16'(k));
            check({15'h0, o_alert_pin}, {15'h0, ((k[2:1] == 2'b10) ? |{vh, vl}
                : (k[2:1] == 2'b01) ? i_busy : 1'b0) ^ !k[0]});
        end
        HOST.wr(4'h2, 16'h0006);
        vh = 4'h0;
        vl = 4'h0;
        stat = 8'h00;
        last[15] = 1'b0;
        rd(4'h2, 16'h0004);
        rd(4'h1, 16'h0000);
        rd(4'h0, last);
        check({15'h0, o_alert_pin}, 16'h0001);
        smp(3'd3, 12'h012);
        HOST.wr(4'h1, 16'h00ff);
        stat = 8'h00;
        rd(4'h1, 16'h0000);
        $display("clears and pin done");
        lim(2, 2, 12'hfff);
        lim(2, 0, 12'h000);
        lim(2, 1, 12'hfff);
        for (int i = 0; i < 6; i++)
            smp(3'd2, 12'($random(seed)));
        rd(4'ha, {4'h0, up[2]});
        rd(4'hb, {4'h0, lo[2]});
        rd(4'h1, 16'h0000);
        $display("min max done");
        // a sample offered while the block is frozen must leave no trace
        @(negedge i_clk_sys);
        i_ce = 1'b0;
        i_sample_valid = 1'b1;
        i_sample = '{3'd4, 12'h5a5};
        @(negedge i_clk_sys);
        i_sample_valid = 1'b0;
        i_ce = 1'b1;
        rd(4'h0, last);
        $display("clock enable done");
        do_reset(1'b1);
        rd(4'h6, 16'h0002);
        smp(3'd5, 12'hfff);
        rd(4'h0, last);
        $display("10-bit variant done");
        repeat (4) @(negedge i_clk_sys);
        print_verdict();
    end
endmodule
